/* File: src/ocfg_pkg.sv */
// Constants shared by the output clocking configuration block
package ocfg_pkg;

   // ----------------------------------------
   // Serial frame layout
   // ----------------------------------------
   localparam int FRAME_BITS = 32;
   localparam logic [4:0] FRAME_LAST_BIT = 5'h1f;
   localparam logic [11:0] FRAME_HEADER = 12'h001;
   localparam int HDR_MSB = 31;
   localparam int HDR_LSB = 20;
   localparam int ADDR_MSB = 19;
   localparam int ADDR_LSB = 16;
   localparam int DATA_MSB = 15;
   localparam int DATA_LSB = 0;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [3:0] CFG_ADDR = 4'h1;
   localparam logic [15:0] CFG_RESET = 16'hb2ff;
   localparam int DUTY_STABILIZER_EN_BIT = 12;
   localparam int DDR_PHASE_SEL_BIT = 11;
   localparam int RATE_SELECT_N_BIT = 10;
   localparam int SWING_SELECT_BIT = 9;
   localparam int EDGE_SEL_BIT = 8;

   // ----------------------------------------
   // Normal-mode settings not set by a pin
   // ----------------------------------------
   localparam logic NORMAL_DUTY_STABILIZER_EN = 1'b1;
   localparam logic NORMAL_DDR_PHASE_SEL = 1'b0;

   // ----------------------------------------
   // Output clock slots (four system clocks a period)
   // ----------------------------------------
   localparam logic [1:0] SLOT_0 = 2'h0;
   localparam logic [1:0] SLOT_1 = 2'h1;
   localparam logic [1:0] SLOT_2 = 2'h2;
   localparam logic [1:0] SLOT_3 = 2'h3;

endpackage : ocfg_pkg

/* File: src/ocfg_frame_if.sv */
// Decoded serial frame passed from the receiver to the register core
interface ocfg_frame_if;
   logic valid;
   logic header_ok;
   logic [3:0] addr;
   logic [15:0] data;

   modport rx
   (
      output valid,
      output header_ok,
      output addr,
      output data
   );

   modport core
   (
      input valid,
      input header_ok,
      input addr,
      input data
   );
endinterface : ocfg_frame_if

/* File: src/ocfg_serial_rx.sv */
// Three-wire serial write receiver, sampled on the system clock
module ocfg_serial_rx
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic serial_clk_pin,
   input wire logic serial_data_in_pin,
   input wire logic serial_select_n_pin,
   ocfg_frame_if.rx frame
);

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic sclk_s1_r, sclk_s2_r, sclk_s3_r;
   logic sdat_s1_r, sdat_s2_r;
   logic ssel_s1_r, ssel_s2_r;
   logic [4:0] bit_cnt_r;
   logic [30:0] shift_r;
   logic sclk_rise;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sclk_s1_r <= 1'b0;
         sclk_s2_r <= 1'b0;
         sclk_s3_r <= 1'b0;
         sdat_s1_r <= 1'b0;
         sdat_s2_r <= 1'b0;
         ssel_s1_r <= 1'b1;
         ssel_s2_r <= 1'b1;
      end
      else
      begin
         sclk_s1_r <= serial_clk_pin;
         sclk_s2_r <= sclk_s1_r;
         sclk_s3_r <= sclk_s2_r;
         sdat_s1_r <= serial_data_in_pin;
         sdat_s2_r <= sdat_s1_r;
         ssel_s1_r <= serial_select_n_pin;
         ssel_s2_r <= ssel_s1_r;
      end
   end

   // Data and clock share latency, so setup around the edge is kept
   assign sclk_rise = sclk_s2_r & ~sclk_s3_r & ~ssel_s2_r; // see RULE_16

   // ----------------------------------------
   // Bit counter and shifter
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bit_cnt_r <= 5'h00;
         shift_r <= 31'h00000000;
      end
      else if (ssel_s2_r)
      begin
         bit_cnt_r <= 5'h00;
      end
      else if (sclk_rise)
      begin
         // Wraps so a new frame can start on the 33rd clock
         bit_cnt_r <= bit_cnt_r + 5'h01; // see RULE_17
         shift_r <= {shift_r[29:0], sdat_s2_r}; // see RULE_15
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         frame.valid <= 1'b0;
         frame.header_ok <= 1'b0;
         frame.addr <= 4'h0;
         frame.data <= 16'h0000;
      end
      else
      begin
         frame.valid <= sclk_rise && (bit_cnt_r == ocfg_pkg::FRAME_LAST_BIT);
         frame.header_ok <= (shift_r[30:19] == ocfg_pkg::FRAME_HEADER); // see RULE_15
         frame.addr <= shift_r[18:15];
         frame.data <= {shift_r[14:0], sdat_s2_r};
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   AST_SELECT_CLEARS_COUNT: assert property ( // see RULE_16
      @(posedge clk) disable iff (!rst_n)
      ssel_s2_r |=> (bit_cnt_r == 5'h00) && !frame.valid)
      else $error("bit counter not cleared by idle select");

   AST_BACK_TO_BACK: assert property ( // see RULE_17
      @(posedge clk) disable iff (!rst_n)
      (sclk_rise && bit_cnt_r == ocfg_pkg::FRAME_LAST_BIT) |=> (bit_cnt_r == 5'h00 || ssel_s2_r))
      else $error("counter did not wrap after the last frame bit");

endmodule : ocfg_serial_rx

/* File: src/ocfg_top.sv */
// Output clocking configuration register with output clock and data pacing

// What this block does
// RULE_01: Eight write-only registers exist; only configuration is kept, none read back.
// RULE_02: In normal control mode register contents are ignored; pins govern instead.
// RULE_03: Power-on reset loads the configuration register at address 1h with 0xB2FF.
// RULE_04: Controller clears dual-edge-sampling enable before writing configuration; the controller model never writes it.
// RULE_05: Controller writes bit15 one, bit14 zero, bit13 one, bits7..0 ones.
// RULE_06: Stabilizer bit one enables duty-cycle correction; zero bypasses it.
// RULE_07: DDR phase bit zero aligns clock edges with data; one puts edges mid-cell.
// RULE_08: Rate-select zero outputs a word on every rising and falling clock edge.
// RULE_09: Rate-select one outputs one word per clock period on the chosen edge.
// RULE_10: Swing bit one selects 710 mV, zero 510 mV, mirroring the swing pin.
// RULE_11: SDR with edge bit one changes data on the rising true clock edge.
// RULE_12: SDR with edge bit zero changes data on the falling true clock edge.
// RULE_13: Edge bit acts in extended mode as the edge pin does in normal mode.
// RULE_14: Reset defaults: swing one; phase, rate-select and edge zero.
// RULE_15: Frame is 32 bits MSB first: header 0x001, 4-bit address, 16 data bits.
// RULE_16: Serial data sampled on rising serial clock while select is low.
// RULE_17: Next frame may start on the 33rd serial clock without raising select.
// RULE_18: Bad header or other address leaves the configuration register unchanged.
module ocfg_top
(
   input wire logic CLK_SYS,
   input wire logic RESET_N,
   input wire logic SERIAL_CLK,
   input wire logic SERIAL_DATA_IN,
   input wire logic SERIAL_SELECT_N,
   input wire logic EXT_MODE,
   input wire logic SWING_PIN,
   input wire logic EDGE_PIN,
   input wire logic RATE_PIN_N,
   input wire logic [7:0] SAMPLE_WORD,
   output logic DUTY_STABILIZER_EN,
   output logic DDR_PHASE_SEL,
   output logic RATE_SELECT_N,
   output logic SWING_SELECT,
   output logic EDGE_SEL,
   output logic OUTPUT_CLOCK,
   output logic [7:0] DATA_OUT,
   output logic WORD_TAKEN
);

   // ----------------------------------------
   // Serial receiver
   // ----------------------------------------
   ocfg_frame_if frame_if ();

   ocfg_serial_rx u_rx
   (
      .clk(CLK_SYS),
      .rst_n(RESET_N),
      .serial_clk_pin(SERIAL_CLK),
      .serial_data_in_pin(SERIAL_DATA_IN),
      .serial_select_n_pin(SERIAL_SELECT_N),
      .frame(frame_if.rx)
   );

   // ----------------------------------------
   // Mode and strap pin synchronisers
   // ----------------------------------------
   logic [3:0] pin_raw;
   logic [3:0] pin_s1_r;
   logic [3:0] pin_s2_r;
   logic ext_s, swing_pin_s, edge_pin_s, rate_pin_n_s;

   assign pin_raw = {EXT_MODE, SWING_PIN, EDGE_PIN, RATE_PIN_N};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_sync
         always_ff @(posedge CLK_SYS or negedge RESET_N)
         begin
            if (!RESET_N)
            begin
               pin_s1_r[gi] <= 1'b0;
               pin_s2_r[gi] <= 1'b0;
            end
            else
            begin
               pin_s1_r[gi] <= pin_raw[gi];
               pin_s2_r[gi] <= pin_s1_r[gi];
            end
         end
      end
   endgenerate

   assign ext_s = pin_s2_r[3];
   assign swing_pin_s = pin_s2_r[2];
   assign edge_pin_s = pin_s2_r[1];
   assign rate_pin_n_s = pin_s2_r[0];

   // ----------------------------------------
   // Configuration register
   // ----------------------------------------
   logic [15:0] cfg_r;
   logic cfg_wr;

   // Other addresses belong to registers this block does not hold
   assign cfg_wr = frame_if.valid && frame_if.header_ok
                   && (frame_if.addr == ocfg_pkg::CFG_ADDR); // see RULE_01, see RULE_18

   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         cfg_r <= ocfg_pkg::CFG_RESET; // see RULE_03, see RULE_14
      end
      else if (cfg_wr)
      begin
         // Fixed bits are stored as sent; nothing reads them back
         cfg_r <= frame_if.data; // see RULE_05
      end
   end

   // ----------------------------------------
   // Effective settings
   // ----------------------------------------
   logic duty_nxt, phase_nxt, rate_n_nxt, swing_nxt, edge_nxt;

   always_comb
   begin
      if (ext_s)
      begin
         duty_nxt = cfg_r[ocfg_pkg::DUTY_STABILIZER_EN_BIT]; // see RULE_06
         phase_nxt = cfg_r[ocfg_pkg::DDR_PHASE_SEL_BIT];
         rate_n_nxt = cfg_r[ocfg_pkg::RATE_SELECT_N_BIT];
         swing_nxt = cfg_r[ocfg_pkg::SWING_SELECT_BIT]; // see RULE_10
         edge_nxt = cfg_r[ocfg_pkg::EDGE_SEL_BIT]; // see RULE_13
      end
      else
      begin
         duty_nxt = ocfg_pkg::NORMAL_DUTY_STABILIZER_EN; // see RULE_02
         phase_nxt = ocfg_pkg::NORMAL_DDR_PHASE_SEL;
         rate_n_nxt = rate_pin_n_s;
         swing_nxt = swing_pin_s;
         edge_nxt = edge_pin_s;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         DUTY_STABILIZER_EN <= 1'b0;
         DDR_PHASE_SEL <= 1'b0;
         RATE_SELECT_N <= 1'b0;
         SWING_SELECT <= 1'b0;
         EDGE_SEL <= 1'b0;
      end
      else
      begin
         DUTY_STABILIZER_EN <= duty_nxt;
         DDR_PHASE_SEL <= phase_nxt;
         RATE_SELECT_N <= rate_n_nxt;
         SWING_SELECT <= swing_nxt;
         EDGE_SEL <= edge_nxt;
      end
   end

   // ----------------------------------------
   // Output clock and data pacing
   // ----------------------------------------
   logic [1:0] slot_r;
   logic clk_ph0, clk_ph90, oclk_nxt, upd;

   // Zero phase: edges on slots 3 and 1; quarter phase: edges on 0 and 2
   assign clk_ph0 = (slot_r == ocfg_pkg::SLOT_3) || (slot_r == ocfg_pkg::SLOT_0);
   assign clk_ph90 = (slot_r == ocfg_pkg::SLOT_0) || (slot_r == ocfg_pkg::SLOT_1);
   // Phase only matters in DDR
   assign oclk_nxt = (!RATE_SELECT_N && DDR_PHASE_SEL) ? clk_ph90 : clk_ph0; // see RULE_07

   always_comb
   begin
      if (!RATE_SELECT_N)
      begin
         upd = (slot_r == ocfg_pkg::SLOT_1) || (slot_r == ocfg_pkg::SLOT_3); // see RULE_08
      end
      else if (EDGE_SEL)
      begin
         upd = (slot_r == ocfg_pkg::SLOT_3); // see RULE_09, see RULE_11
      end
      else
      begin
         upd = (slot_r == ocfg_pkg::SLOT_1); // see RULE_09, see RULE_12
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         slot_r <= ocfg_pkg::SLOT_0;
         OUTPUT_CLOCK <= 1'b0;
      end
      else
      begin
         slot_r <= slot_r + 2'h1;
         OUTPUT_CLOCK <= oclk_nxt;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         DATA_OUT <= 8'h00;
         WORD_TAKEN <= 1'b0;
      end
      else
      begin
         WORD_TAKEN <= upd;
         if (upd)
         begin
            DATA_OUT <= SAMPLE_WORD;
         end
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   logic [2:0] mode_prev_r;
   logic [2:0] mode_age_r;
   logic mode_stable;

   // Mode history, so checks can skip the one irregular period after a change
   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         mode_prev_r <= 3'h0;
         mode_age_r <= 3'h0;
      end
      else
      begin
         mode_prev_r <= {RATE_SELECT_N, DDR_PHASE_SEL, EDGE_SEL};
         mode_age_r <= !mode_stable ? 3'h0 : mode_age_r + {2'h0, mode_age_r != 3'h7};
      end
   end

   assign mode_stable = (mode_prev_r == {RATE_SELECT_N, DDR_PHASE_SEL, EDGE_SEL});

   AST_WRITE_LOADS: assert property ( // see RULE_15
      @(posedge CLK_SYS) disable iff (!RESET_N)
      cfg_wr |=> cfg_r == $past(frame_if.data))
      else $error("valid configuration frame not stored");

   AST_BAD_FRAME_HOLDS: assert property ( // see RULE_18
      @(posedge CLK_SYS) disable iff (!RESET_N)
      (frame_if.valid && (!frame_if.header_ok || frame_if.addr != ocfg_pkg::CFG_ADDR))
      |=> $stable(cfg_r))
      else $error("rejected frame changed the configuration");

   AST_NORMAL_PINS: assert property ( // see RULE_02
      @(posedge CLK_SYS) disable iff (!RESET_N)
      !ext_s |=> (SWING_SELECT == $past(swing_pin_s)) && (EDGE_SEL == $past(edge_pin_s))
                 && (DUTY_STABILIZER_EN == ocfg_pkg::NORMAL_DUTY_STABILIZER_EN))
      else $error("normal mode not following pins");

   AST_EXT_FIELDS: assert property ( // see RULE_10
      @(posedge CLK_SYS) disable iff (!RESET_N)
      ext_s |=> (SWING_SELECT == $past(cfg_r[ocfg_pkg::SWING_SELECT_BIT]))
                && (DUTY_STABILIZER_EN == $past(cfg_r[ocfg_pkg::DUTY_STABILIZER_EN_BIT])))
      else $error("extended mode not following register");

   AST_DDR_ALIGNED: assert property ( // see RULE_07
      @(posedge CLK_SYS) disable iff (!RESET_N)
      (WORD_TAKEN && mode_stable && !RATE_SELECT_N && !DDR_PHASE_SEL)
      |-> OUTPUT_CLOCK != $past(OUTPUT_CLOCK))
      else $error("zero-phase DDR data not on a clock edge");

   AST_DDR_MIDCELL: assert property ( // see RULE_07
      @(posedge CLK_SYS) disable iff (!RESET_N)
      (WORD_TAKEN && mode_stable && !RATE_SELECT_N && DDR_PHASE_SEL)
      |-> OUTPUT_CLOCK == $past(OUTPUT_CLOCK))
      else $error("quarter-phase DDR data on a clock edge");

   AST_DDR_TWO_WORDS: assert property ( // see RULE_08
      @(posedge CLK_SYS) disable iff (!RESET_N)
      (WORD_TAKEN && !RATE_SELECT_N && $stable(RATE_SELECT_N))
      |=> !WORD_TAKEN ##1 (WORD_TAKEN || RATE_SELECT_N))
      else $error("DDR not giving two words a period");

   AST_SDR_ONE_WORD: assert property ( // see RULE_09
      @(posedge CLK_SYS) disable iff (!RESET_N)
      (WORD_TAKEN && RATE_SELECT_N && $stable(RATE_SELECT_N) && $stable(EDGE_SEL))
      |=> (!WORD_TAKEN || (mode_age_r < 3'h2))[*3])
      else $error("SDR gave more than one word a period");

   AST_SDR_RISING: assert property ( // see RULE_11
      @(posedge CLK_SYS) disable iff (!RESET_N)
      (WORD_TAKEN && mode_stable && RATE_SELECT_N && EDGE_SEL) |-> $rose(OUTPUT_CLOCK))
      else $error("SDR rising-edge data not on rising clock");

   AST_SDR_FALLING: assert property ( // see RULE_12
      @(posedge CLK_SYS) disable iff (!RESET_N)
      (WORD_TAKEN && mode_stable && RATE_SELECT_N && !EDGE_SEL) |-> $fell(OUTPUT_CLOCK))
      else $error("SDR falling-edge data not on falling clock");

endmodule : ocfg_top

/* File: dv/ocfg_ctrl_model.sv */
// Behavioural external controller driving the three-wire serial write port
module ocfg_ctrl_model
(
   input wire logic clk,
   output logic sclk,
   output logic serial_data_in,
   output logic sel_n
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      sclk = 1'b0;
      serial_data_in = 1'b1;
      sel_n = 1'b1;
   end

   // ----------------------------------------
   // Frame sender
   // ----------------------------------------
   // Serial clock stands low outside frames; 160 ns period inside them.
   // The dual-edge enable register is never addressed, so it stays clear
   task automatic send(input logic [31:0] f, input int nbits, input bit hold);
      int i;
      @(negedge clk);
      sel_n = 1'b0;
      for (i = 31; i >= 32 - nbits; i--)
      begin
         serial_data_in = f[i];
         repeat (8) @(negedge clk);
         sclk = 1'b1;
         repeat (8) @(negedge clk);
         sclk = 1'b0;
      end
      // Keeping select low lets the next frame start on the 33rd clock
      if (!hold)
      begin
         repeat (4) @(negedge clk);
         sel_n = 1'b1;
         // Released line shows no stale bit
         serial_data_in = ~serial_data_in;
      end
      repeat (8) @(negedge clk);
   endtask : send
endmodule : ocfg_ctrl_model

/* File: dv/ocfg_top_tb_top.sv */
// Self-checking testbench for the output clocking configuration block
module ocfg_top_tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic ext_mode = 1'b1;
   logic swing_pin = 1'b1;
   logic edge_pin = 1'b0;
   logic rate_pin_n = 1'b0;
   logic [7:0] sample_word = 8'h00;
   logic sclk, serial_data_in, sel_n, duty, phase, rate, swing, edge_out, oclk, taken;
   logic [7:0] dout;
   int err_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [4:0] tbl [6] = '{5'h12, 5'h0d, 5'h00, 5'h1f, 5'h0a, 5'h06};

   always #5 clk_sys = ~clk_sys;

   ocfg_ctrl_model ctrl_u (.clk(clk_sys), .sclk(sclk), .serial_data_in(serial_data_in), .sel_n(sel_n));

   ocfg_top dut_u
   (
      .CLK_SYS(clk_sys), .RESET_N(reset_n), .SERIAL_CLK(sclk), .SERIAL_DATA_IN(serial_data_in),
      .SERIAL_SELECT_N(sel_n), .EXT_MODE(ext_mode), .SWING_PIN(swing_pin),
      .EDGE_PIN(edge_pin), .RATE_PIN_N(rate_pin_n), .SAMPLE_WORD(sample_word),
      .DUTY_STABILIZER_EN(duty), .DDR_PHASE_SEL(phase), .RATE_SELECT_N(rate),
      .SWING_SELECT(swing), .EDGE_SEL(edge_out), .OUTPUT_CLOCK(oclk), .DATA_OUT(dout),
      .WORD_TAKEN(taken)
   );

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Field order {stabilizer, phase, rate, swing, edge}
   function automatic logic [31:0] frame(input logic [11:0] h, input logic [3:0] a,
                                         input logic [4:0] f);
      return {h, a, 3'h5, f, 8'hff};
   endfunction : frame

   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   task automatic check_cfg(input logic [4:0] exp);
      @(negedge clk_sys);
      check("config fields", {3'h0, exp}, {3'h0, duty, phase, rate, swing, edge_out});
   endtask : check_cfg

   // Counts words over 16 cycles and ties each to the output clock edge, or to mid-cell in quarter-phase DDR
   task automatic pace(input logic [4:0] f);
      int words;
      int bad;
      logic prev;
      words = 0;
      bad = 0;
      repeat (8) @(negedge clk_sys);
      prev = oclk;
      repeat (16)
      begin
         @(negedge clk_sys);
         if (taken === 1'b1)
         begin
            words++;
            if (dout !== sample_word)
               bad++;
            if (f[2] ? (f[0] ? !(oclk && !prev) : !(!oclk && prev))
                     : (f[3] ? (oclk !== prev) : (oclk === prev)))
               bad++;
         end
         prev = oclk;
         sample_word = sample_word + 8'h01;
      end
      check("words per 16 cycles", f[2] ? 8'h04 : 8'h08, words[7:0]);
      check("word alignment", 8'h00, bad[7:0]);
   endtask : pace

   task tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : tally_and_finish

   // Run takes about 6300 cycles; the ceiling leaves ample slack
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         $display("ERROR cycle limit expected 0 seen %0d", cyc);
         tally_and_finish();
      end
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      repeat (4) @(negedge clk_sys);
      reset_n = 1'b1;
      repeat (6) @(negedge clk_sys);
      check_cfg(5'h12);
      pace(5'h12);
      foreach (tbl[i])
      begin
         ctrl_u.send(frame(ocfg_pkg::FRAME_HEADER, ocfg_pkg::CFG_ADDR, tbl[i]), 32, 1'b0);
         check_cfg(tbl[i]);
         pace(tbl[i]);
      end
      ctrl_u.send(frame(12'h003, ocfg_pkg::CFG_ADDR, 5'h1f), 32, 1'b0);
      check_cfg(5'h06);
      ctrl_u.send(frame(ocfg_pkg::FRAME_HEADER, 4'h2, 5'h1f), 32, 1'b0);
      check_cfg(5'h06);
      // Select raised after 20 bits must discard the partial frame
      ctrl_u.send(frame(ocfg_pkg::FRAME_HEADER, ocfg_pkg::CFG_ADDR, 5'h1f), 20, 1'b0);
      check_cfg(5'h06);
      ctrl_u.send(frame(ocfg_pkg::FRAME_HEADER, ocfg_pkg::CFG_ADDR, 5'h0d), 32, 1'b1);
      check_cfg(5'h0d);
      ctrl_u.send(frame(ocfg_pkg::FRAME_HEADER, ocfg_pkg::CFG_ADDR, 5'h12), 32, 1'b0);
      check_cfg(5'h12);
      ext_mode = 1'b0;
      swing_pin = 1'b0;
      edge_pin = 1'b1;
      rate_pin_n = 1'b1;
      repeat (6) @(negedge clk_sys);
      check_cfg(5'h15);
      pace(5'h15);
      ctrl_u.send(frame(ocfg_pkg::FRAME_HEADER, ocfg_pkg::CFG_ADDR, 5'h00), 32, 1'b0);
      check_cfg(5'h15);
      ext_mode = 1'b1;
      repeat (6) @(negedge clk_sys);
      check_cfg(5'h00);
      tally_and_finish();
   end
endmodule : ocfg_top_tb_top
